// File: design/mchp_pkg.sv
/*
 Shared constants for the motion controller host port: bus widths, reset
 and busy timing, pulse modes. Assumes a single 20 MHz system clock.
*/
package mchp_pkg;
	localparam int CLK_HZ          = 20_000_000;
	localparam int NUM_AXES        = 4;
	localparam int ADDR_W          = 4;
	localparam int DATA_W          = 16;
	localparam int NUM_REGS        = 16;
	localparam int RESET_MIN_CLKS  = 5;
	localparam int TRIG_MIN_CLKS   = 5;
	localparam int BUSY_CLKS       = 3;
	localparam int FILT_CLKS       = 4;
	localparam int SPEED_W         = 16;
	localparam int CMD_REG         = 0;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic        MODE_TWO_PULSE = 1'b0;
	localparam logic        MODE_STEP_DIR  = 1'b1;
	typedef enum logic [1:0] {MCHP_IDLE, MCHP_WRLOW, MCHP_RDLOW} mchp_bus_t;
endpackage : mchp_pkg

// File: design/mchp_if.sv
/*
 Pin-level carrier between the controller and its host.
 Assumes the testbench resolves data and interrupt wires from the enables.
*/
`timescale 1ns/100ps
interface mchp_if;
	import mchp_pkg::*;
	logic                  chipSelectLow;
	logic                  readStrobeLow;
	logic                  writeStrobeLow;
	logic [ADDR_W-1:0]     hostAddressLines;
	logic [DATA_W-1:0]     hostDataFromHost;
	logic                  hostDataHostOe;
	logic [DATA_W-1:0]     hostDataFromDev;
	logic                  hostDataDevOe;
	logic                  busWidthSelect;
	logic                  resetInputLow;
	logic                  extInterpTrigger;
	logic                  commandBusyLow;
	logic                  hostInterruptLowOe;
	logic                  sysClockOut;
	logic [NUM_AXES-1:0]   plusPulseOrStepOut;
	logic [NUM_AXES-1:0]   minusPulseOrDirectionOut;
	modport dev (
		input  chipSelectLow, readStrobeLow, writeStrobeLow, hostAddressLines,
		input  hostDataFromHost, hostDataHostOe, busWidthSelect, resetInputLow,
		input  extInterpTrigger,
		output hostDataFromDev, hostDataDevOe, commandBusyLow, hostInterruptLowOe,
		output sysClockOut, plusPulseOrStepOut, minusPulseOrDirectionOut
	);
	modport host (
		output chipSelectLow, readStrobeLow, writeStrobeLow, hostAddressLines,
		output hostDataFromHost, hostDataHostOe, busWidthSelect, resetInputLow,
		output extInterpTrigger,
		input  hostDataFromDev, hostDataDevOe, commandBusyLow, hostInterruptLowOe,
		input  sysClockOut, plusPulseOrStepOut, minusPulseOrDirectionOut
	);
endinterface : mchp_if

// File: design/mchp_device.sv
/*
 Device end: asynchronous host port, register file, busy, interrupt,
 system clock divider, interpolation trigger and per-axis pulse outputs.
 Assumes pins arrive asynchronously and the host drives the other modport.
*/
`timescale 1ns/100ps
module mchp_device #(
	parameter int AXES = mchp_pkg::NUM_AXES
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	mchp_if.dev                pins,
	input  wire logic [AXES-1:0] intCause,
	output logic               cmdStrobe,
	output logic [15:0]        cmdCode
);
	import mchp_pkg::*;

	logic [4:0] syncA;
	logic [4:0] syncB;
	always_ff @(posedge clk) begin
		syncA <= {pins.resetInputLow, pins.extInterpTrigger, pins.chipSelectLow,
			pins.readStrobeLow, pins.writeStrobeLow};
		syncB <= syncA;
	end
	wire rstPinLow = syncB[4];
	wire trigS     = syncB[3];
	wire wrS       = syncB[0];

	// reset needs more than five clocks low
	logic [3:0] rstCnt;
	logic       devRst;
	always_ff @(posedge clk) begin
		// Count only while the pin is held low
		if (sys_rst || rstPinLow)
			rstCnt <= 4'h0;
		else if (rstCnt != 4'(RESET_MIN_CLKS))
			rstCnt <= rstCnt + 4'h1;
	end
	wire rstNow = sys_rst || (rstPinLow == 1'b0 && rstCnt == 4'(RESET_MIN_CLKS));
	always_ff @(posedge clk)
		devRst <= rstNow;

	logic sclk;
	always_ff @(posedge clk) begin
		if (devRst || !rstPinLow)
			sclk <= 1'b0;
		else
			sclk <= ~sclk;
	end
	assign pins.sysClockOut = sclk;

	// write taken at strobe rise, data stable then
	logic wrPrev;
	always_ff @(posedge clk)
		wrPrev <= devRst ? 1'b1 : wrS;
	logic [ADDR_W-1:0] addrHold;
	logic [DATA_W-1:0] dataHold;
	always_ff @(posedge clk) begin
		// Bus held stable while strobe low, so sample late
		if (!wrS) begin
			addrHold <= pins.hostAddressLines;
			dataHold <= pins.hostDataFromHost;
		end
	end
	wire wrRise = wrS && !wrPrev;

	function automatic logic [ADDR_W-1:0] regIndex(input logic [ADDR_W-1:0] a,
		input logic wide);
		regIndex = wide ? {1'b0, a[ADDR_W-2:0]} : a;
	endfunction

	logic [15:0] regs [NUM_REGS];
	wire         wide = pins.busWidthSelect;
	wire [ADDR_W-1:0] wIdx = regIndex(addrHold, wide);
	logic [2:0]  busyCnt;
	wire         busy = busyCnt != 3'h0;
	wire         isCmd = wIdx == ADDR_W'(CMD_REG);
	wire         cmdTake = wrRise && isCmd && !busy;
	always_ff @(posedge clk) begin
		if (devRst) begin
			for (int i = 0; i < NUM_REGS; i++)
				regs[i] <= REG_RST;
		end else if (wrRise && (!isCmd || !busy)) begin
			regs[wIdx] <= wide ? dataHold : {8'h00, dataHold[7:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (devRst)
			busyCnt <= 3'h0;
		else if (cmdTake)
			busyCnt <= 3'(BUSY_CLKS);
		else if (busy)
			busyCnt <= busyCnt - 3'h1;
	end
	assign pins.commandBusyLow = ~busy;
	always_ff @(posedge clk) begin
		cmdStrobe <= cmdTake && !devRst;
		cmdCode   <= devRst ? REG_RST : regs[CMD_REG];
	end

	wire [ADDR_W-1:0] rIdx = regIndex(pins.hostAddressLines, wide);
	logic [15:0] rdData;
	always_ff @(posedge clk)
		rdData <= devRst ? REG_RST : regs[rIdx];
	assign pins.hostDataFromDev = wide ? rdData : {8'h00, rdData[7:0]};
	// drive only selected read; pins direct to avoid bus fights
	assign pins.hostDataDevOe = !pins.chipSelectLow && !pins.readStrobeLow;

	// open drain interrupt, mask in register 1
	wire [15:0] intMask = regs[1];
	assign pins.hostInterruptLowOe = |(intCause & intMask[AXES-1:0]);

	logic [2:0] filtCnt;
	logic       trigF;
	always_ff @(posedge clk) begin
		if (devRst) begin
			filtCnt <= 3'(FILT_CLKS);
			trigF   <= 1'b1;
		end else if (trigS && filtCnt != 3'(FILT_CLKS)) begin
			filtCnt <= filtCnt + 3'h1;
		end else if (!trigS && filtCnt != 3'h0) begin
			filtCnt <= filtCnt - 3'h1;
		end else begin
			trigF <= filtCnt != 3'h0;
		end
	end
	logic trigPrev;
	always_ff @(posedge clk)
		trigPrev <= devRst ? 1'b1 : trigF;
	wire trigFall = trigPrev && !trigF;

	// Axis config: reg 2 mode bits, reg 3 direction, reg 4 enable, reg 5 speed
	wire [15:0] modeR = regs[2];
	wire [15:0] dirR  = regs[3];
	wire [15:0] runR  = regs[4];
	wire [15:0] divR  = regs[5];
	wire [15:0] interpR = regs[6];

	logic [AXES-1:0] pulse;
	logic [AXES-1:0] extPend;
	logic [SPEED_W-1:0] phase;
	always_ff @(posedge clk) begin
		if (devRst || phase >= divR)
			phase <= '0;
		else
			phase <= phase + SPEED_W'(1);
	end
	wire halfTick = phase >= divR;
	always_ff @(posedge clk) begin
		if (devRst) begin
			pulse   <= '0;
			extPend <= '0;
		end else begin
			for (int i = 0; i < AXES; i++) begin
				if (trigFall && interpR[i])
					extPend[i] <= 1'b1;
				if (halfTick) begin
					if (runR[i])
						pulse[i] <= ~pulse[i];
					else if (extPend[i] || pulse[i]) begin
						pulse[i]   <= ~pulse[i];
						extPend[i] <= trigFall && interpR[i] ? 1'b1 : pulse[i] ? 1'b0 : 1'b1;
					end else
						pulse[i] <= 1'b0;
				end
			end
		end
	end

	// two pulse split, step on plus pin
	for (genvar g = 0; g < AXES; g++) begin : g_out
		wire step = modeR[g] == MODE_STEP_DIR;
		assign pins.plusPulseOrStepOut[g] = step ? pulse[g] : pulse[g] && !dirR[g];
		assign pins.minusPulseOrDirectionOut[g] = step ? dirR[g] : pulse[g] && dirR[g];
	end
endmodule : mchp_device

// File: design/mchp_host.sv
/*
 Host end: turns single user requests into chip select, read and write
 strobes, waits for busy before commands, and drives reset and trigger.
 Assumes the device modport on the other side.
*/
`timescale 1ns/100ps
module mchp_host (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	mchp_if.host                             pins,
	input  wire logic                        reqValid,
	input  wire logic                        reqWrite,
	input  wire logic [mchp_pkg::ADDR_W-1:0] reqAddr,
	input  wire logic [mchp_pkg::DATA_W-1:0] reqData,
	input  wire logic                        wide,
	input  wire logic                        trigReq,
	output logic                             reqReady,
	output logic                             rspValid,
	output logic [mchp_pkg::DATA_W-1:0]      rspData
);
	import mchp_pkg::*;

	mchp_bus_t state;
	logic [3:0] cnt;
	logic [3:0] trigCnt;
	logic [1:0] busyS;
	logic [DATA_W-1:0] rdS1;
	logic [DATA_W-1:0] rdS2;
	// Strobes held long enough for the device synchronisers
	localparam logic [3:0] STROBE_CLKS = 4'h6;
	wire cmdBusy = !busyS[1];

	always_ff @(posedge clk) begin
		busyS <= {busyS[0], pins.commandBusyLow};
		rdS1  <= pins.hostDataFromDev;
		rdS2  <= rdS1;
	end

	assign reqReady = state == MCHP_IDLE && !(reqWrite && cmdBusy);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state    <= MCHP_IDLE;
			cnt      <= 4'h0;
			rspValid <= 1'b0;
			rspData  <= '0;
			pins.chipSelectLow    <= 1'b1;
			pins.readStrobeLow    <= 1'b1;
			pins.writeStrobeLow   <= 1'b1;
			pins.hostAddressLines <= '0;
			pins.hostDataFromHost <= '0;
			pins.hostDataHostOe   <= 1'b0;
		end else begin
			rspValid <= 1'b0;
			case (state)
				MCHP_IDLE: begin
					if (reqValid && reqReady) begin
						pins.chipSelectLow    <= 1'b0;
						pins.hostAddressLines <= reqAddr;
						pins.hostDataFromHost <= reqData;
						pins.hostDataHostOe   <= reqWrite;
						pins.writeStrobeLow   <= !reqWrite;
						pins.readStrobeLow    <= reqWrite;
						cnt   <= STROBE_CLKS;
						state <= reqWrite ? MCHP_WRLOW : MCHP_RDLOW;
					end
				end
				MCHP_WRLOW: begin
					// select and address held; data past edge
					if (cnt != 4'h0)
						cnt <= cnt - 4'h1;
					else if (!pins.writeStrobeLow)
						pins.writeStrobeLow <= 1'b1;
					else begin
						pins.chipSelectLow  <= 1'b1;
						pins.hostDataHostOe <= 1'b0;
						state <= MCHP_IDLE;
					end
				end
				MCHP_RDLOW: begin
					if (cnt != 4'h0)
						cnt <= cnt - 4'h1;
					else begin
						rspValid <= 1'b1;
						rspData  <= rdS2;
						pins.readStrobeLow <= 1'b1;
						pins.chipSelectLow <= 1'b1;
						state <= MCHP_IDLE;
					end
				end
				default: state <= MCHP_IDLE;
			endcase
		end
	end

	// reset pin low for more than five clocks
	logic [3:0] rstCnt;
	always_ff @(posedge clk) begin
		if (sys_rst)
			rstCnt <= 4'(RESET_MIN_CLKS + 3);
		else if (rstCnt != 4'h0)
			rstCnt <= rstCnt - 4'h1;
	end
	assign pins.resetInputLow  = rstCnt == 4'h0;
	assign pins.busWidthSelect = wide;

	// trigger idles high, low long enough
	always_ff @(posedge clk) begin
		if (sys_rst)
			trigCnt <= 4'h0;
		else if (trigCnt != 4'h0)
			trigCnt <= trigCnt - 4'h1;
		else if (trigReq)
			trigCnt <= 4'(TRIG_MIN_CLKS + FILT_CLKS + 3);
	end
	assign pins.extInterpTrigger = trigCnt == 4'h0;
endmodule : mchp_host

// File: dv/mchp_properties.sv
/*
 Checker on the wires between host end and device end.
 Assumes one clock domain and instantiation beside the interface.
*/
`timescale 1ns/100ps
module mchp_properties (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        chipSelectLow,
	input wire logic        readStrobeLow,
	input wire logic        writeStrobeLow,
	input wire logic [3:0]  hostAddressLines,
	input wire logic [15:0] hostDataFromHost,
	input wire logic        hostDataHostOe,
	input wire logic        hostDataDevOe,
	input wire logic        resetInputLow,
	input wire logic        extInterpTrigger,
	input wire logic        commandBusyLow,
	input wire logic        sysClockOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_data_drive_gate: assert property (
		hostDataDevOe == (!chipSelectLow && !readStrobeLow))
		else $error("data enable disagrees with select and read");
	chk_strobe_select: assert property (
		!readStrobeLow || !writeStrobeLow |-> !chipSelectLow)
		else $error("strobe low without select");
	chk_write_addr_hold: assert property (
		(!writeStrobeLow)[*2] |-> $stable(hostAddressLines))
		else $error("address moved during write strobe");
	chk_write_data_edge: assert property ($rose(writeStrobeLow) |->
		$stable(hostDataFromHost) && $past(hostDataHostOe))
		else $error("write data not held at strobe rise");
	chk_trigger_low_width: assert property (
		$fell(extInterpTrigger) |-> (!extInterpTrigger)[*5])
		else $error("trigger low pulse too short");
	chk_busy_width: assert property ($fell(commandBusyLow) |->
		(!commandBusyLow)[*3] ##1 commandBusyLow)
		else $error("busy low not three clocks");
	chk_no_write_busy: assert property ($fell(writeStrobeLow) |-> $past(commandBusyLow))
		else $error("write started while busy");
	chk_sclk_half_rate: assert property (resetInputLow[*6] |-> sysClockOut != $past(sysClockOut))
		else $error("system clock not toggling every clock");
	chk_sclk_reset_still: assert property (
		(!resetInputLow)[*6] |-> $stable(sysClockOut))
		else $error("system clock toggles in reset");
	cover property ($fell(commandBusyLow));
	cover property ($fell(extInterpTrigger));
	cover property (!chipSelectLow && !readStrobeLow);
endmodule : mchp_properties

// File: dv/mchp_tb.sv
/*
 Self-checking bench: host end and device end joined by the interface.
 Assumes a 50 ns clock and the handshake timing of the host end.
*/
`timescale 1ns/100ps
module mchp_tb;
	import mchp_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hostRst = 1'b0;
	logic        reqValid = 1'b0;
	logic        reqWrite = 1'b0;
	logic [3:0]  reqAddr = 4'h0;
	logic [15:0] reqData = 16'h0000;
	logic        wide = 1'b1;
	logic        trigReq = 1'b0;
	logic [3:0]  intCause = 4'h0;
	logic        reqReady;
	logic        rspValid;
	logic [15:0] rspData;
	logic        cmdStrobe;
	logic [15:0] cmdCode;
	logic [15:0] rd;
	logic [15:0] nCmd = 16'h0000;
	int          failures = 0;
	int          n_checks = 0;
	mchp_if mchp_if_i ();
	mchp_device mchp_device_i (.clk(clk), .sys_rst(sys_rst), .pins(mchp_if_i.dev),
		.intCause(intCause), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode));
	mchp_host mchp_host_i (.clk(clk), .sys_rst(sys_rst || hostRst), .pins(mchp_if_i.host),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
		.wide(wide), .trigReq(trigReq), .reqReady(reqReady), .rspValid(rspValid),
		.rspData(rspData));
	mchp_properties mchp_properties_i (.clk(clk), .sys_rst(sys_rst),
		.chipSelectLow(mchp_if_i.chipSelectLow), .readStrobeLow(mchp_if_i.readStrobeLow),
		.writeStrobeLow(mchp_if_i.writeStrobeLow), .hostAddressLines(mchp_if_i.hostAddressLines),
		.hostDataFromHost(mchp_if_i.hostDataFromHost), .hostDataHostOe(mchp_if_i.hostDataHostOe),
		.hostDataDevOe(mchp_if_i.hostDataDevOe), .resetInputLow(mchp_if_i.resetInputLow),
		.extInterpTrigger(mchp_if_i.extInterpTrigger),
		.commandBusyLow(mchp_if_i.commandBusyLow), .sysClockOut(mchp_if_i.sysClockOut));
	initial forever #25 clk = ~clk;
	always @(posedge clk) if (cmdStrobe === 1'b1) nCmd <= nCmd + 16'h0001;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tmo(input int i);
		if (i >= 200) begin
			failures++;
			$display("unexpected at %0t: wait ran out", $time);
			stop_test();
		end
	endtask : tmo
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		int i = 0;
		@(posedge clk);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr  <= a;
		reqData  <= d;
		do begin
			@(negedge clk);
			i++;
		end while (reqReady !== 1'b1 && i < 200);
		tmo(i);
		@(posedge clk);
		reqValid <= 1'b0;
		i = 0;
		while (!w && rspValid !== 1'b1 && i < 200) begin
			@(negedge clk);
			i++;
		end
		tmo(i);
		rd = rspData;
	endtask : acc
	// Count negedges until axis one output reaches the level
	task automatic lvl(input logic v, output logic [15:0] n);
		n = 16'h0000;
		while (mchp_if_i.plusPulseOrStepOut[1] !== v && n < 16'd200) begin
			@(negedge clk);
			n++;
		end
		tmo(int'(n));
	endtask : lvl
	task automatic t_regs();
		acc(1'b1, 4'h5, 16'hA5C3);
		acc(1'b0, 4'h5, 16'h0000);
		chk(rd, 16'hA5C3);
		acc(1'b1, 4'hD, 16'hA50F);
		acc(1'b0, 4'h5, 16'h0000);
		chk(rd, 16'hA50F);
		@(posedge clk);
		wide <= 1'b0;
		acc(1'b0, 4'h5, 16'h0000);
		chk(rd, 16'h000F);
		acc(1'b1, 4'hD, 16'hBE77);
		acc(1'b0, 4'h5, 16'h0000);
		chk(rd, 16'h000F);
		acc(1'b0, 4'hD, 16'h0000);
		chk(rd, 16'h0077);
		@(posedge clk);
		wide <= 1'b1;
		$display("register test done");
	endtask : t_regs
	task automatic t_cmd();
		logic [15:0] n0 = nCmd;
		acc(1'b1, 4'h0, 16'h0027);
		acc(1'b1, 4'h0, 16'h0100);
		repeat (12) @(posedge clk);
		chk(nCmd - n0, 16'h0002);
		chk(cmdCode, 16'h0100);
		$display("command test done");
	endtask : t_cmd
	task automatic t_irq();
		acc(1'b1, 4'h1, 16'h0002);
		intCause <= 4'h1;
		// Mask write lands about ten clocks after acceptance
		repeat (12) @(posedge clk);
		chk({15'h0, mchp_if_i.hostInterruptLowOe}, 16'h0000);
		intCause <= 4'h2;
		repeat (6) @(posedge clk);
		chk({15'h0, mchp_if_i.hostInterruptLowOe}, 16'h0001);
		intCause <= 4'h0;
		repeat (6) @(posedge clk);
		chk({15'h0, mchp_if_i.hostInterruptLowOe}, 16'h0000);
		$display("interrupt test done");
	endtask : t_irq
	task automatic t_trig(input logic m, input logic d, input logic [15:0] ep,
		input logic [15:0] em);
		logic [15:0] np = 16'h0000;
		logic [15:0] nm = 16'h0000;
		logic        pp;
		logic        pm;
		acc(1'b1, 4'h5, 16'h0002);
		acc(1'b1, 4'h2, {15'h0, m});
		acc(1'b1, 4'h3, {15'h0, d});
		acc(1'b1, 4'h6, 16'h0001);
		// Let the axis selection land before the trigger edge
		repeat (12) @(posedge clk);
		trigReq <= 1'b1;
		@(posedge clk);
		trigReq <= 1'b0;
		@(negedge clk);
		pp = mchp_if_i.plusPulseOrStepOut[0];
		pm = mchp_if_i.minusPulseOrDirectionOut[0];
		repeat (60) begin
			@(negedge clk);
			if (!pp && mchp_if_i.plusPulseOrStepOut[0]) np++;
			if (!pm && mchp_if_i.minusPulseOrDirectionOut[0]) nm++;
			pp = mchp_if_i.plusPulseOrStepOut[0];
			pm = mchp_if_i.minusPulseOrDirectionOut[0];
		end
		chk(np, ep);
		chk(nm, em);
		if (m) chk({15'h0, pm}, {15'h0, d});
		$display("trigger test done");
	endtask : t_trig
	task automatic t_duty();
		logic [15:0] hi;
		logic [15:0] lo;
		acc(1'b1, 4'h6, 16'h0000);
		acc(1'b1, 4'h2, 16'h0000);
		acc(1'b1, 4'h5, 16'h0003);
		acc(1'b1, 4'h4, 16'h0002);
		lvl(1'b0, hi);
		lvl(1'b1, hi);
		lvl(1'b0, hi);
		lvl(1'b1, lo);
		chk(hi, lo);
		acc(1'b1, 4'h4, 16'h0000);
		$display("duty test done");
	endtask : t_duty
	task automatic t_reset();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (16) @(posedge clk);
		acc(1'b0, 4'h5, 16'h0000);
		chk(rd, 16'h0000);
		acc(1'b1, 4'h5, 16'h1234);
		acc(1'b0, 4'h5, 16'h0000);
		chk(rd, 16'h1234);
		// Host end alone pulls the reset pin; device must clear through it
		@(posedge clk);
		hostRst <= 1'b1;
		@(posedge clk);
		hostRst <= 1'b0;
		repeat (16) @(posedge clk);
		acc(1'b0, 4'h5, 16'h0000);
		chk(rd, 16'h0000);
		$display("reset test done");
	endtask : t_reset
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (16) @(posedge clk);
		t_regs();
		t_cmd();
		t_irq();
		t_trig(1'b0, 1'b0, 16'h0001, 16'h0000);
		t_trig(1'b0, 1'b1, 16'h0000, 16'h0001);
		t_trig(1'b1, 1'b1, 16'h0001, 16'h0000);
		t_duty();
		t_reset();
		stop_test();
	end
endmodule : mchp_tb
